// ---- verilog/ssh_exec.sv ----
// Executor for subtract-with-carry immediate, S-page store/load and halt.
// Assumes the issue port is driven from logic on ref_clk and an AXI4-Lite master
// on the same clock; the watchdog itself sits outside and obeys wdt_clear.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
module ssh_exec #(
  parameter int unsigned DATA_W = ssh_pkg::DATA_W
) (
  input  wire logic                        ref_clk,
  input  wire logic                        srst,
  // Instruction issue
  input  wire logic                        instr_valid,
  input  wire logic [1:0]                  instr_op,
  input  wire logic [DATA_W-1:0]           instr_operand,
  output logic                             instr_ready,
  // Core state
  output logic [DATA_W-1:0]                working_register,
  output logic                             carry_flag,
  output logic                             digit_carry_flag,
  output logic                             zero_flag,
  output logic                             timeout_flag_n,
  output logic                             powerdown_flag_n,
  output logic                             halted,
  output logic                             wdt_clear,
  output logic                             watchdog_prescaler_clear,
  // AXI4-Lite slave
  input  wire logic [ssh_pkg::AXI_AW-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [ssh_pkg::AXI_AW-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready
);

  typedef struct packed {
    logic [DATA_W-1:0]          work;
    logic                       c;
    logic                       dig_c;
    logic                       z;
    logic                       tmo_n;
    logic                       pwrdn_n;
    logic                       halted;
    logic                       wdt_clr;
    logic                       ready;
    logic                       ld_pend;
    logic                       enable;
    logic                       aw_got;
    logic                       w_got;
    logic [ssh_pkg::AXI_AW-1:0] awaddr;
    logic [31:0]                wdata;
    logic                       wstrb0;
    logic                       awready;
    logic                       wready;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       arready;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
  } ssh_state_s;

  ssh_state_s                       st;
  ssh_state_s                       next_st;
  logic       [DATA_W-1:0]          spage_rdata;
  logic       [DATA_W-1:0]          work_eff;
  logic                             issue;
  logic                             in_range;
  logic                             spage_we;
  logic       [ssh_pkg::SPAGE_AW-1:0] spage_addr;
  logic       [DATA_W:0]            sum;
  logic       [ssh_pkg::NIB_W:0]    nib_sum;
  logic                             wr_fire;

  assign issue      = instr_valid && st.ready;
  assign spage_addr = instr_operand[ssh_pkg::SPAGE_AW-1:0];
  // Upper operand bits must be zero too, otherwise 32+n would alias n
  assign in_range   = (instr_operand[DATA_W-1:ssh_pkg::SPAGE_AW] == '0)
                      && (spage_addr <= ssh_pkg::SPAGE_LAST);
  // A load taken last cycle has its data only now; forward it so that a
  // back-to-back instruction sees the loaded accumulator
  assign work_eff   = st.ld_pend ? spage_rdata : st.work;
  assign spage_we   = issue && (instr_op == ssh_pkg::SSH_OP_STORE_TO_SPAGE)
                      && in_range;
  assign sum        = {1'b0, instr_operand} + {1'b0, ~work_eff}
                      + {{DATA_W{1'b0}}, st.c};
  assign nib_sum    = {1'b0, instr_operand[ssh_pkg::NIB_W-1:0]}
                      + {1'b0, ~work_eff[ssh_pkg::NIB_W-1:0]}
                      + {{ssh_pkg::NIB_W{1'b0}}, st.c};
  assign wr_fire    = st.aw_got && st.w_got && !st.bvalid;

  ssh_spage_mem #(
    .WIDTH (DATA_W),
    .DEPTH (ssh_pkg::SPAGE_DEPTH),
    .AW    (ssh_pkg::SPAGE_AW)
  ) ssh_spage_mem_inst (
    .ref_clk (ref_clk),
    .we      (spage_we),
    .waddr   (spage_addr),
    .wdata   (work_eff),
    .raddr   (spage_addr),
    .rdata   (spage_rdata)
  );

  always_comb
  begin
    next_st         = st;
    next_st.work    = work_eff;
    next_st.ld_pend = 1'b0;
    next_st.wdt_clr = 1'b0;

    if (issue)
    begin
      case (instr_op)
        ssh_pkg::SSH_OP_SUB_IMM_WITH_CARRY:
        begin
          next_st.work = sum[DATA_W-1:0];
          next_st.c    = sum[DATA_W];
          next_st.dig_c = nib_sum[ssh_pkg::NIB_W];
          next_st.z    = (sum[DATA_W-1:0] == '0);
        end
        ssh_pkg::SSH_OP_STORE_TO_SPAGE:
        begin
          // Memory write happens through spage_we; nothing else moves
          next_st.work = work_eff;
        end
        ssh_pkg::SSH_OP_LOAD_FROM_SPAGE:
        begin
          next_st.ld_pend = in_range;
        end
        ssh_pkg::SSH_OP_HALT:
        begin
          next_st.wdt_clr = 1'b1;
          next_st.tmo_n   = 1'b1;
          next_st.pwrdn_n = 1'b0;
          next_st.halted  = 1'b1;
        end
        default:
        begin
          next_st.work = work_eff;
        end
      endcase
    end

    // AXI write channel: address and data taken in either order
    if (s_axi_awvalid && st.awready)
    begin
      next_st.aw_got  = 1'b1;
      next_st.awaddr  = s_axi_awaddr;
      next_st.awready = 1'b0;
    end
    if (s_axi_wvalid && st.wready)
    begin
      next_st.w_got  = 1'b1;
      next_st.wdata  = s_axi_wdata;
      next_st.wstrb0 = s_axi_wstrb[0];
      next_st.wready = 1'b0;
    end
    if (wr_fire)
    begin
      next_st.bvalid = 1'b1;
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      case (st.awaddr)
        ssh_pkg::REG_CTRL:
        begin
          next_st.bresp = ssh_pkg::RESP_OKAY;
          if (st.wstrb0)
          begin
            next_st.enable = st.wdata[ssh_pkg::CTRL_ENABLE_BIT];
            // A halt issued in this same cycle wins over the wake request
            if (st.wdata[ssh_pkg::CTRL_WAKE_BIT] && !(issue
                && instr_op == ssh_pkg::SSH_OP_HALT))
            begin
              next_st.halted = 1'b0;
            end
          end
        end
        ssh_pkg::REG_STATUS,
        ssh_pkg::REG_WORK:
        begin
          next_st.bresp = ssh_pkg::RESP_OKAY;
        end
        default:
        begin
          next_st.bresp = ssh_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st.bvalid && s_axi_bready)
    begin
      next_st.bvalid  = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready  = 1'b1;
    end

    // AXI read channel
    if (s_axi_arvalid && st.arready)
    begin
      next_st.arready = 1'b0;
      next_st.rvalid  = 1'b1;
      next_st.rdata   = '0;
      next_st.rresp   = ssh_pkg::RESP_OKAY;
      case (s_axi_araddr)
        ssh_pkg::REG_CTRL:
        begin
          next_st.rdata[ssh_pkg::CTRL_ENABLE_BIT] = st.enable;
        end
        ssh_pkg::REG_STATUS:
        begin
          next_st.rdata[ssh_pkg::ST_CARRY_BIT]  = st.c;
          next_st.rdata[ssh_pkg::ST_DIG_C_BIT]   = st.dig_c;
          next_st.rdata[ssh_pkg::ST_ZERO_BIT]    = st.z;
          next_st.rdata[ssh_pkg::ST_TMO_N_BIT]   = st.tmo_n;
          next_st.rdata[ssh_pkg::ST_PWRDN_N_BIT] = st.pwrdn_n;
          next_st.rdata[ssh_pkg::ST_HALTED_BIT] = st.halted;
        end
        ssh_pkg::REG_WORK:
        begin
          next_st.rdata[DATA_W-1:0] = work_eff;
        end
        default:
        begin
          next_st.rresp = ssh_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st.rvalid && s_axi_rready)
    begin
      next_st.rvalid  = 1'b0;
      next_st.arready = 1'b1;
    end

    // Issue stalls while halted or disabled; wake-up is a software write
    next_st.ready = next_st.enable && !next_st.halted;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      st         <= '0;
      st.work    <= ssh_pkg::WORK_RST;
      st.tmo_n   <= ssh_pkg::TMO_N_RST;
      st.pwrdn_n <= ssh_pkg::PWRDN_N_RST;
      st.enable  <= ssh_pkg::CTRL_ENABLE_RST;
      st.ready   <= ssh_pkg::CTRL_ENABLE_RST;
      st.awready <= 1'b1;
      st.wready  <= 1'b1;
      st.arready <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // A pending load has updated st.work by the time the next edge shows it
  assign instr_ready              = st.ready;
  assign working_register         = st.work;
  assign carry_flag               = st.c;
  assign digit_carry_flag         = st.dig_c;
  assign zero_flag                = st.z;
  assign timeout_flag_n           = st.tmo_n;
  assign powerdown_flag_n         = st.pwrdn_n;
  assign halted                   = st.halted;
  assign wdt_clear                = st.wdt_clr;
  assign watchdog_prescaler_clear = st.wdt_clr;
  assign s_axi_awready            = st.awready;
  assign s_axi_wready             = st.wready;
  assign s_axi_bresp              = st.bresp;
  assign s_axi_bvalid             = st.bvalid;
  assign s_axi_arready            = st.arready;
  assign s_axi_rdata              = st.rdata;
  assign s_axi_rresp              = st.rresp;
  assign s_axi_rvalid             = st.rvalid;

endmodule

// ---- verilog/ssh_pkg.sv ----
// Constants shared by the instruction executor and its S-page memory.
// Assumes a single 20 MHz core clock and a synchronous active-high reset.
// Operation
// - Immediate subtract-with-carry: imm plus inverted accumulator plus carry into accumulator.
// - That subtract updates zero, digit-carry and carry; carry set means no borrow.
// - Store writes accumulator to S-page register 0..21; accumulator and flags unchanged.
// - Load copies S-page register 0..21 into accumulator; register and flags unchanged.
// - Load completes in one instruction cycle.
// - Halt clears watchdog counter and watchdog prescaler to zero.
// - Halt sets time-out flag, clears power-down flag, then core enters halt mode.
package ssh_pkg;

  localparam int unsigned DATA_W      = 8;
  localparam int unsigned SPAGE_DEPTH = 22;
  localparam int unsigned SPAGE_AW    = 5;
  localparam logic [SPAGE_AW-1:0] SPAGE_LAST = 5'h15;
  localparam int unsigned NIB_W       = 4;

  // Instruction codes on the issue port
  typedef enum logic [1:0] {
    SSH_OP_SUB_IMM_WITH_CARRY = 2'h0,
    SSH_OP_STORE_TO_SPAGE     = 2'h1,
    SSH_OP_LOAD_FROM_SPAGE    = 2'h2,
    SSH_OP_HALT               = 2'h3
  } ssh_op_e;

  // AXI4-Lite register map, byte addresses
  localparam int unsigned AXI_AW   = 4;
  localparam logic [AXI_AW-1:0] REG_CTRL   = 4'h0;
  localparam logic [AXI_AW-1:0] REG_STATUS = 4'h4;
  localparam logic [AXI_AW-1:0] REG_WORK   = 4'h8;

  // Control register fields
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_WAKE_BIT   = 1;
  localparam logic        CTRL_ENABLE_RST = 1'b1;

  // Status register fields
  localparam int unsigned ST_CARRY_BIT    = 0;
  localparam int unsigned ST_DIG_C_BIT    = 1;
  localparam int unsigned ST_ZERO_BIT     = 2;
  localparam int unsigned ST_TMO_N_BIT    = 3;
  localparam int unsigned ST_PWRDN_N_BIT  = 4;
  localparam int unsigned ST_HALTED_BIT   = 5;

  // Reset values of the flags and accumulator
  localparam logic [DATA_W-1:0] WORK_RST    = 8'h00;
  localparam logic              TMO_N_RST   = 1'b1;
  localparam logic              PWRDN_N_RST = 1'b1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- verilog/ssh_spage_mem.sv ----
// S-page special-function register storage, one write and one read port.
// Assumes the write and read come from logic on the same clock; read data is registered.
`timescale 1ns/100ps
module ssh_spage_mem #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 22,
  parameter int unsigned AW    = 5
) (
  input  wire logic             ref_clk,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Contents are not reset: software is expected to initialise the page
  always_ff @(posedge ref_clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// ---- test/ssh_exec_sva.sv ----
// Concurrent checks on the executor's issue port, flags and AXI handshakes.
// Assumes it is bound to ssh_exec and sees only that module's ports.
`timescale 1ns/100ps
module ssh_exec_sva (
  input wire logic       ref_clk,
  input wire logic       srst,
  input wire logic       instr_valid,
  input wire logic [1:0] instr_op,
  input wire logic [7:0] instr_operand,
  input wire logic       instr_ready,
  input wire logic [7:0] working_register,
  input wire logic       carry_flag,
  input wire logic       digit_carry_flag,
  input wire logic       zero_flag,
  input wire logic       timeout_flag_n,
  input wire logic       powerdown_flag_n,
  input wire logic       halted,
  input wire logic       wdt_clear,
  input wire logic       watchdog_prescaler_clear,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid
);
  logic       tk;
  logic [1:0] ld_q;
  logic [8:0] sum;
  logic [4:0] low;
  assign tk  = instr_valid && instr_ready;
  assign sum = {1'b0, instr_operand} + {1'b0, ~working_register} + 9'(carry_flag);
  assign low = {1'b0, instr_operand[3:0]} + {1'b0, ~working_register[3:0]} + 5'(carry_flag);
  // The accumulator port lags a load by two edges, so skip checks that read it then
  always_ff @(posedge ref_clk)
    ld_q <= srst ? 2'h0 : {ld_q[0], tk && instr_op == 2'h2};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence sub_tk; tk && instr_op == 2'h0 && ld_q == 2'h0; endsequence
  sequence st_tk; tk && instr_op == 2'h1 && ld_q == 2'h0; endsequence
  sequence halt_tk; tk && instr_op == 2'h3; endsequence
  sequence clr_pulse;
    wdt_clear && watchdog_prescaler_clear ##1 !wdt_clear && !watchdog_prescaler_clear;
  endsequence
  a_sub_result: assert property (sub_tk |=> working_register == $past(sum[7:0]))
    else $error("subtract result wrong");
  a_sub_flags: assert property (sub_tk |=> carry_flag == $past(sum[8]) &&
    digit_carry_flag == $past(low[4]) && zero_flag == (working_register == 8'h00))
    else $error("subtract flags wrong");
  a_store_keeps: assert property (st_tk |=> $stable(working_register) &&
    $stable(carry_flag) && $stable(digit_carry_flag) && $stable(zero_flag))
    else $error("store changed state");
  a_load_flags: assert property (tk && instr_op == 2'h2 |=> $stable(carry_flag) &&
    $stable(digit_carry_flag) && $stable(zero_flag))
    else $error("load changed flags");
  a_one_cycle: assert property (tk && instr_op != 2'h3 |=> instr_ready)
    else $error("next instruction refused");
  a_halt_clear: assert property (halt_tk |=> clr_pulse)
    else $error("watchdog clear pulse wrong");
  a_halt_flags: assert property (halt_tk |=> halted && timeout_flag_n &&
    !powerdown_flag_n && $stable(carry_flag))
    else $error("halt flags wrong");
  a_halt_hold: assert property (halted |-> !instr_ready)
    else $error("issue open while halted");
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
endmodule
bind ssh_exec ssh_exec_sva ssh_exec_sva_inst (.*);

// ---- test/ssh_exec_test.sv ----
// Self-checking bench for ssh_exec: issue port, AXI4-Lite registers and halt.
// Assumes the checker is bound separately; one 20 MHz clock drives all.
`timescale 1ns/100ps
module ssh_exec_test;
  logic        ref_clk, srst, instr_valid, instr_ready, m_c, m_dig, m_z, halted;
  logic        carry_flag, digit_carry_flag, zero_flag, timeout_flag_n, powerdown_flag_n;
  logic        wdt_clear, watchdog_prescaler_clear, s_axi_bvalid, s_axi_bready;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  instr_op, s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [7:0]  instr_operand, working_register, m_work, sv0, sv21;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [7:0]  imm [8] = '{8'h00, 8'h06, 8'h05, 8'h07, 8'h09, 8'h00, 8'h80, 8'h3C};
  int          error_cnt, num_checks, cyc;

  ssh_exec ssh_exec_inst (.*);

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      wrap_up;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Ready is read at the falling edge so the take never races the design's update
  task automatic issue(input logic [1:0] op, input logic [7:0] v);
    instr_valid   <= 1'b1;
    instr_op      <= op;
    instr_operand <= v;
    do
      @(negedge ref_clk);
    while (instr_ready !== 1'b1);
    @(posedge ref_clk);
  endtask

  task automatic sub(input logic [7:0] i);
    logic [8:0] s;
    logic [4:0] l;
    s      = {1'b0, i} + {1'b0, ~m_work} + 9'(m_c);
    l      = {1'b0, i[3:0]} + {1'b0, ~m_work[3:0]} + 5'(m_c);
    m_work = s[7:0];
    m_c    = s[8];
    m_dig  = l[4];
    m_z    = (s[7:0] == 8'h00);
    issue(2'h0, i);
  endtask

  // Ends just after a rising edge, so the next driver starts where it should
  task automatic chk_core;
    @(negedge ref_clk);
    chk("work_reg", m_work, working_register);
    chk("flags", {m_c, m_dig, m_z}, {carry_flag, digit_carry_flag, zero_flag});
    @(posedge ref_clk);
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic aw, w, done;
    done = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (done !== 1'b1)
    begin
      @(negedge ref_clk);
      aw   = s_axi_awready;
      w    = s_axi_wready;
      done = s_axi_bvalid;
      rsp  = s_axi_bresp;
      @(posedge ref_clk);
      if (aw)
        s_axi_awvalid <= 1'b0;
      if (w)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a);
    logic ar, done;
    done = 1'b0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (done !== 1'b1)
    begin
      @(negedge ref_clk);
      ar   = s_axi_arready;
      done = s_axi_rvalid;
      rd   = s_axi_rdata;
      rsp  = s_axi_rresp;
      @(posedge ref_clk);
      if (ar)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask

  initial
  begin
    srst = 1'b1;
    {instr_valid, instr_op, instr_operand, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_wdata, m_work, m_c, m_dig, m_z} = '0;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    @(negedge ref_clk);
    chk("reset_out", 3'h7, {timeout_flag_n, powerdown_flag_n, instr_ready});
    chk_core;
    axi_rd(ssh_pkg::REG_STATUS);
    chk("status", 32'h18, rd);
    $display("test reset done");
    foreach (imm[k])
    begin
      sub(imm[k]);
      instr_valid <= 1'b0;
      chk_core;
    end
    sub(8'h33);
    sub(8'hC4);
    instr_valid <= 1'b0;
    chk_core;
    $display("test subtract done");
    sv21 = m_work;
    issue(2'h1, 8'h15);
    sub(8'h5A);
    sv0 = m_work;
    issue(2'h1, 8'h00);
    issue(2'h1, 8'h16);
    instr_valid <= 1'b0;
    chk_core;
    issue(2'h2, 8'h16);
    issue(2'h2, 8'h15);
    m_work = sv21;
    sub(8'h11);
    instr_valid <= 1'b0;
    chk_core;
    issue(2'h2, 8'h00);
    instr_valid <= 1'b0;
    m_work = sv0;
    @(negedge ref_clk);
    chk_core;
    $display("test move done");
    axi_rd(ssh_pkg::REG_WORK);
    chk("work", m_work, rd);
    axi_rd(4'hC);
    chk("bad read", {ssh_pkg::RESP_SLVERR, 8'h00}, {rsp, rd[7:0]});
    axi_wr(4'hC, 32'hFF);
    chk("bad write", ssh_pkg::RESP_SLVERR, rsp);
    axi_wr(ssh_pkg::REG_WORK, 32'h0);
    chk("ro write", ssh_pkg::RESP_OKAY, rsp);
    axi_wr(ssh_pkg::REG_CTRL, 32'h0);
    @(negedge ref_clk);
    chk("disabled", 1'b0, instr_ready);
    @(posedge ref_clk);
    axi_wr(ssh_pkg::REG_CTRL, 32'h1);
    axi_rd(ssh_pkg::REG_CTRL);
    chk("ctrl", {ssh_pkg::RESP_OKAY, 8'h01}, {rsp, rd[7:0]});
    axi_rd(ssh_pkg::REG_WORK);
    chk("work kept", m_work, rd);
    $display("test registers done");
    issue(2'h3, 8'h00);
    instr_valid <= 1'b0;
    @(negedge ref_clk);
    chk("halt", 6'h3C, {wdt_clear, watchdog_prescaler_clear, halted, timeout_flag_n,
                        powerdown_flag_n, instr_ready});
    @(negedge ref_clk);
    chk("pulse", 2'h0, {wdt_clear, watchdog_prescaler_clear});
    chk_core;
    axi_rd(ssh_pkg::REG_STATUS);
    chk("status", {3'h5, m_z, m_dig, m_c}, rd);
    axi_wr(ssh_pkg::REG_CTRL, 32'h3);
    @(negedge ref_clk);
    chk("wake", 2'h1, {halted, instr_ready});
    $display("test halt done");
    wrap_up;
  end
endmodule
